// file: rtl/dac_ctrl_map.svh
// Offsets, field positions, reset values and timing counts of the DAC control register block.
// Assumes it is included by bare name from the control register module and the bench.
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH

// ==========================================================================
// Special-function word addresses (both register-select bits at zero)
`define SFR_ADDR_SOFT_PWRUP  4'h9
`define SFR_ADDR_MONITOR    4'hA
`define SFR_ADDR_CTRL       4'hC

// ==========================================================================
// Field positions, 14-bit layout
`define W_PD_POS      13
`define W_REFSEL_POS  12
`define W_BOOST_POS   11
`define W_INTREF_POS  10
`define W_MON_POS     9
`define W_THERM_POS   8
`define W_TGL_HI_POS  3
`define W_TGL_LO_POS  2
`define W_MONCH_LSB   8

// ==========================================================================
// Field positions, 12-bit layout
`define N_PD_POS      11
`define N_REFSEL_POS  10
`define N_BOOST_POS   9
`define N_INTREF_POS  8
`define N_MON_POS     7
`define N_THERM_POS   6
`define N_TGL_HI_POS  1
`define N_TGL_LO_POS  0
`define N_MONCH_LSB   6

// ==========================================================================
// Reset values and constants
`define PD_HIZ_RST    1'h1
`define BOOST_RST     1'h0
`define INTREF_RST    1'h0
`define W_MON_RST     1'h1
`define N_MON_RST     1'h0
`define THERM_RST     1'h0
`define TGL_RST       1'h0
`define MONCH_RST     6'h3F
`define MONCH_TRISTATE 6'h3F

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 5
`define EXIT_PD_NS    8000
`define WAKE_CNT_W    11
`define EXIT_PD_CYC   ((`EXIT_PD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/dac_ctrl_pkg.sv
// Types shared by the DAC control register block.
// Assumes dac_ctrl_map.svh is on the include path.
package dac_ctrl_pkg;

  // ========================================================================
  // Amplifier power state
  typedef enum logic [1:0] {
    PWR_ON,
    PWR_DOWN,
    PWR_WAKE
  } amp_pwr_e;

  typedef logic [13:0] ctrl_word_t;
  typedef logic [5:0]  mon_chan_t;

endpackage

// file: rtl/dac_ctrl_reg.sv
// Control register of a multichannel voltage-output DAC, written by special-function words.
// Assumes the serial framing logic hands over decoded words on clk_i, one-cycle valid.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module dac_ctrl_reg #(
  parameter bit NARROW       = 1'b0,
  parameter int NUM_CHANNELS = 16,
  parameter bit REF_HI_RST   = 1'b1
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Decoded special-function word
  input  wire logic                    sfr_word_valid_i,
  input  wire logic                    reg_select_hi_i,
  input  wire logic                    reg_select_lo_i,
  input  wire logic [3:0]              sfr_address_field_i,
  input  wire logic [13:0]             word_data_bits_i,
  // Pins
  input  wire logic                    load_dac_pin_n_i,
  input  wire logic                    die_hot_i,
  // Control register fields
  output logic                         pd_output_state_bit_o,
  output logic                         ref_level_select_bit_o,
  output logic                         amp_boost_bit_o,
  output logic                         int_ref_enable_bit_o,
  output logic                         chan_monitor_enable_bit_o,
  output logic                         thermal_protect_enable_bit_o,
  output logic                         toggle_group_hi_enable_o,
  output logic                         toggle_group_lo_enable_o,
  output dac_ctrl_pkg::ctrl_word_t     ctrl_readback_o,
  // Monitor multiplexer
  output dac_ctrl_pkg::mon_chan_t      mon_channel_o,
  output logic                         monitor_output_pin_oe_o,
  // Amplifier power and toggle selects
  output logic                         amp_enable_o,
  output logic                         amp_ready_o,
  output logic                         thermal_trip_o,
  output logic [NUM_CHANNELS-1:0]      toggle_sel_b_o
);

  // ========================================================================
  // Field positions for the chosen variant
  function automatic int pick(input bit narrow, input int wide_pos, input int narrow_pos);
    return narrow ? narrow_pos : wide_pos;
  endfunction

  localparam int P_PD     = pick(NARROW, `W_PD_POS, `N_PD_POS);
  localparam int P_REFSEL = pick(NARROW, `W_REFSEL_POS, `N_REFSEL_POS);
  localparam int P_BOOST  = pick(NARROW, `W_BOOST_POS, `N_BOOST_POS);
  localparam int P_INTREF = pick(NARROW, `W_INTREF_POS, `N_INTREF_POS);
  localparam int P_MON    = pick(NARROW, `W_MON_POS, `N_MON_POS);
  localparam int P_THERM  = pick(NARROW, `W_THERM_POS, `N_THERM_POS);
  localparam int P_TGL_HI = pick(NARROW, `W_TGL_HI_POS, `N_TGL_HI_POS);
  localparam int P_TGL_LO = pick(NARROW, `W_TGL_LO_POS, `N_TGL_LO_POS);
  localparam int P_MONCH  = pick(NARROW, `W_MONCH_LSB, `N_MONCH_LSB);
  localparam logic MON_RST = NARROW ? `N_MON_RST : `W_MON_RST;
  localparam logic [`WAKE_CNT_W-1:0] WAKE_CYC = `WAKE_CNT_W'(`EXIT_PD_CYC);

  // ========================================================================
  // Word decode
  wire logic sfr_sel     = sfr_word_valid_i && !reg_select_hi_i && !reg_select_lo_i;
  wire logic ctrl_wr     = sfr_sel && (sfr_address_field_i == `SFR_ADDR_CTRL);
  wire logic mon_wr      = sfr_sel && (sfr_address_field_i == `SFR_ADDR_MONITOR);
  wire logic soft_pwrup  = sfr_sel && (sfr_address_field_i == `SFR_ADDR_SOFT_PWRUP);
  wire logic [5:0] mon_addr = word_data_bits_i[P_MONCH +: 6];

  // ========================================================================
  // Pin synchronisers
  // The load pin and the comparator flag are asynchronous to clk_i.
  logic [2:0] load_sync_q;
  logic [1:0] hot_sync_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      load_sync_q <= 3'h7;
      hot_sync_q  <= 2'h0;
    end else begin
      load_sync_q <= {load_sync_q[1:0], load_dac_pin_n_i};
      hot_sync_q  <= {hot_sync_q[0], die_hot_i};
    end
  end
  wire logic load_pulse = load_sync_q[2] && !load_sync_q[1];
  wire logic die_hot    = hot_sync_q[1];

  // ========================================================================
  // Control fields
  wire logic pd_d     = ctrl_wr ? word_data_bits_i[P_PD] : pd_output_state_bit_o;
  wire logic ref_d    = ctrl_wr ? word_data_bits_i[P_REFSEL] : ref_level_select_bit_o;
  wire logic boost_d  = ctrl_wr ? word_data_bits_i[P_BOOST] : amp_boost_bit_o;
  wire logic intref_d = ctrl_wr ? word_data_bits_i[P_INTREF] : int_ref_enable_bit_o;
  wire logic mon_d    = ctrl_wr ? word_data_bits_i[P_MON] : chan_monitor_enable_bit_o;
  wire logic therm_d  = ctrl_wr ? word_data_bits_i[P_THERM] : thermal_protect_enable_bit_o;
  wire logic tlo_d    = ctrl_wr ? word_data_bits_i[P_TGL_LO] : toggle_group_lo_enable_o;
  // The upper group has no channels on eight-channel parts.
  wire logic thi_wr   = ctrl_wr ? word_data_bits_i[P_TGL_HI] : toggle_group_hi_enable_o;
  wire logic thi_d    = (NUM_CHANNELS > 8) && thi_wr;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pd_output_state_bit_o        <= `PD_HIZ_RST;
      ref_level_select_bit_o       <= REF_HI_RST;
      amp_boost_bit_o              <= `BOOST_RST;
      int_ref_enable_bit_o         <= `INTREF_RST;
      chan_monitor_enable_bit_o    <= MON_RST;
      thermal_protect_enable_bit_o <= `THERM_RST;
      toggle_group_lo_enable_o     <= `TGL_RST;
      toggle_group_hi_enable_o     <= `TGL_RST;
    end else begin
      pd_output_state_bit_o        <= pd_d;
      ref_level_select_bit_o       <= ref_d;
      amp_boost_bit_o              <= boost_d;
      int_ref_enable_bit_o         <= intref_d;
      chan_monitor_enable_bit_o    <= mon_d;
      thermal_protect_enable_bit_o <= therm_d;
      toggle_group_lo_enable_o     <= tlo_d;
      toggle_group_hi_enable_o     <= thi_d;
    end
  end

  // ========================================================================
  // Readback
  // Don't-care bits are not stored and read as zero.
  dac_ctrl_pkg::ctrl_word_t rb_d;
  always_comb begin
    rb_d           = '0;
    rb_d[P_PD]     = pd_d;
    rb_d[P_REFSEL] = ref_d;
    rb_d[P_BOOST]  = boost_d;
    rb_d[P_INTREF] = intref_d;
    rb_d[P_MON]    = mon_d;
    rb_d[P_THERM]  = therm_d;
    rb_d[P_TGL_HI] = thi_d;
    rb_d[P_TGL_LO] = tlo_d;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_readback_o <= '0;
    end else begin
      ctrl_readback_o <= rb_d;
    end
  end

  // ========================================================================
  // Monitor multiplexer
  // The channel address is kept even while disabled, so enabling the
  // monitor later routes the channel written before.
  wire dac_ctrl_pkg::mon_chan_t monch_d = mon_wr ? mon_addr : mon_channel_o;
  wire logic mon_oe_d = mon_d && (monch_d != `MONCH_TRISTATE);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon_channel_o           <= `MONCH_RST;
      monitor_output_pin_oe_o <= 1'h0;
    end else begin
      mon_channel_o           <= monch_d;
      monitor_output_pin_oe_o <= mon_oe_d;
    end
  end

  // ========================================================================
  // Amplifier power and thermal shutdown
  dac_ctrl_pkg::amp_pwr_e    pwr_q;
  dac_ctrl_pkg::amp_pwr_e    pwr_d;
  logic [`WAKE_CNT_W-1:0]    wake_cnt_q;
  logic [`WAKE_CNT_W-1:0]    wake_cnt_d;
  wire logic thermal_hit = therm_d && die_hot;

  always_comb begin
    pwr_d      = pwr_q;
    wake_cnt_d = wake_cnt_q;
    unique case (pwr_q)
      dac_ctrl_pkg::PWR_ON: begin
        if (thermal_hit) begin
          pwr_d = dac_ctrl_pkg::PWR_DOWN;
        end
      end
      dac_ctrl_pkg::PWR_DOWN: begin
        if (soft_pwrup && !die_hot) begin
          pwr_d      = dac_ctrl_pkg::PWR_WAKE;
          wake_cnt_d = WAKE_CYC;
        end
      end
      dac_ctrl_pkg::PWR_WAKE: begin
        wake_cnt_d = wake_cnt_q - `WAKE_CNT_W'(1);
        if (thermal_hit) begin
          pwr_d = dac_ctrl_pkg::PWR_DOWN;
        end else if (wake_cnt_q == `WAKE_CNT_W'(1)) begin
          pwr_d = dac_ctrl_pkg::PWR_ON;
        end
      end
    endcase
  end

  // The trip flag is only cleared by a cool soft power-up, so a hot
  // reading in that cycle cannot be lost.
  wire logic trip_d = (pwr_d == dac_ctrl_pkg::PWR_DOWN) && (thermal_hit || thermal_trip_o);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_q          <= dac_ctrl_pkg::PWR_ON;
      wake_cnt_q     <= '0;
      amp_enable_o   <= 1'h1;
      amp_ready_o    <= 1'h1;
      thermal_trip_o <= 1'h0;
    end else begin
      pwr_q          <= pwr_d;
      wake_cnt_q     <= wake_cnt_d;
      amp_enable_o   <= pwr_d != dac_ctrl_pkg::PWR_DOWN;
      amp_ready_o    <= pwr_d == dac_ctrl_pkg::PWR_ON;
      thermal_trip_o <= trip_d;
    end
  end

  // ========================================================================
  // Toggle mode
  dac_toggle_bank #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_toggle (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .load_pulse_i (load_pulse),
    .group_en_i   ({toggle_group_hi_enable_o, toggle_group_lo_enable_o}),
    .sel_b_o      (toggle_sel_b_o)
  );

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_cool_pwrup;
    soft_pwrup && !die_hot && (pwr_q == dac_ctrl_pkg::PWR_DOWN);
  endsequence
  sequence s_waking;
    !amp_ready_o && amp_enable_o;
  endsequence

  a_pd_state_write:
    assert property (ctrl_wr |=> pd_output_state_bit_o == $past(word_data_bits_i[P_PD]))
    else $error("power-down state bit not taken from control write");
  a_ref_boost_write:
    assert property (ctrl_wr |=> ref_level_select_bit_o == $past(word_data_bits_i[P_REFSEL])
                     && amp_boost_bit_o == $past(word_data_bits_i[P_BOOST]))
    else $error("reference level or boost bit not taken from control write");
  a_intref_hold:
    assert property (!ctrl_wr |=> $stable(int_ref_enable_bit_o))
    else $error("internal reference enable changed without a control write");
  a_mon_route:
    assert property (mon_wr && mon_d && mon_addr != `MONCH_TRISTATE
                     |=> monitor_output_pin_oe_o && mon_channel_o == $past(mon_addr))
    else $error("monitor write did not route the channel");
  a_mon_tristate:
    assert property (!chan_monitor_enable_bit_o |-> !monitor_output_pin_oe_o)
    else $error("monitor pin driven while monitor disabled");
  a_thermal_down:
    assert property (thermal_protect_enable_bit_o && die_hot && !ctrl_wr
                     |=> !amp_enable_o && thermal_trip_o)
    else $error("hot die did not power down amplifiers");
  a_hot_pwrup_held:
    assert property (soft_pwrup && die_hot && pwr_q == dac_ctrl_pkg::PWR_DOWN
                     |=> !amp_enable_o)
    else $error("soft power-up restored amplifiers while hot");
  a_wake_timing:
    assert property (s_cool_pwrup ##1 (!thermal_hit)[*8] |-> s_waking)
    else $error("amplifiers ready before exit time");
  a_wake_count:
    assert property ($rose(amp_ready_o) |-> $past(wake_cnt_q) == `WAKE_CNT_W'(1))
    else $error("amplifiers ready without full exit count");
  a_toggle_flip:
    assert property (load_pulse && toggle_group_lo_enable_o && $past(toggle_group_lo_enable_o)
                     |=> toggle_sel_b_o[0] != $past(toggle_sel_b_o[0]))
    else $error("enabled channel did not toggle on load pulse");
  a_hi_group_dead:
    assert property ((NUM_CHANNELS <= 8) |-> !toggle_group_hi_enable_o)
    else $error("upper toggle group enabled on eight-channel part");
  a_ignored_bits:
    assert property (!NARROW |-> ctrl_readback_o[7:4] == 4'h0 && ctrl_readback_o[1:0] == 2'h0)
    else $error("don't-care control bits read back nonzero");

endmodule

// file: rtl/dac_toggle_bank.sv
// Per-channel A/B code select for toggle mode, in groups of eight channels.
// Assumes the load pulse is already synchronous to clk_i and one cycle long.
`timescale 1ns/10ps
module dac_toggle_bank #(
  parameter int NUM_CHANNELS = 16
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Control
  input  wire logic                    load_pulse_i,
  input  wire logic [1:0]              group_en_i,
  // Select, 1 picks the B register
  output logic      [NUM_CHANNELS-1:0] sel_b_o
);

  // ========================================================================
  // Channel select flops
  // A channel whose group is disabled falls back to its A code, so that
  // re-enabling a group always starts the square wave from A.
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    wire logic grp_en = group_en_i[ch / 8];
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sel_b_o[ch] <= 1'h0;
      end else if (!grp_en) begin
        sel_b_o[ch] <= 1'h0;
      end else if (load_pulse_i) begin
        sel_b_o[ch] <= !sel_b_o[ch];
      end
    end
  end

endmodule

// file: tb/dac_host_model.sv
// Host side of the decoded word port: issues one special-function word per call.
// Assumes the bench calls send_word from one process and runs clk_i freely.
`timescale 1ns/10ps
module dac_host_model (
  // Clock
  input  wire logic        clk_i,
  // Decoded special-function word
  output logic             sfr_word_valid_o,
  output logic             reg_select_hi_o,
  output logic             reg_select_lo_o,
  output logic [3:0]       sfr_address_field_o,
  output logic [13:0]      word_data_bits_o
);
  initial begin
    sfr_word_valid_o    = 1'h0;
    reg_select_hi_o     = 1'h1;
    reg_select_lo_o     = 1'h1;
    sfr_address_field_o = 4'h0;
    word_data_bits_o    = 14'h0;
  end

  // ==========================================================================
  // Word transfer
  // Lines change at the falling edge and hold across one rising edge; once
  // released they show the inverse so a stale word is never mistaken for a new one.
  task automatic send_word(input logic [1:0] sel, input logic [3:0] addr,
                           input logic [13:0] data);
    @(negedge clk_i);
    sfr_word_valid_o    = 1'h1;
    {reg_select_hi_o, reg_select_lo_o} = sel;
    sfr_address_field_o = addr;
    word_data_bits_o    = data;
    @(negedge clk_i);
    sfr_word_valid_o    = 1'h0;
    {reg_select_hi_o, reg_select_lo_o} = ~sel;
    sfr_address_field_o = ~addr;
    word_data_bits_o    = ~data;
  endtask
endmodule

// file: tb/test_dac_ctrl_register.sv
// Self-checking bench for the 16-channel, 14-bit block and a 12-bit, eight-channel instance.
// Assumes dac_ctrl_map.svh is on the include path and the package is compiled first.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module test_dac_ctrl_register;
  typedef struct packed {
    logic [1:0]  sel;
    logic [3:0]  addr;
    logic [13:0] data;
    logic [13:0] exp_rb;
    logic [13:0] exp_n;
  } row_s;

  logic                     clk_i;
  logic                     sys_rst_i;
  logic                     valid;
  logic                     sel_hi;
  logic                     sel_lo;
  logic [3:0]               addr;
  logic [13:0]              data;
  logic                     load_dac_pin_n;
  logic                     die_hot;
  logic [7:0]               fields;
  logic                     pd, ref_hi, boost, intref, mon, therm, thi, tlo;
  dac_ctrl_pkg::ctrl_word_t readback;
  dac_ctrl_pkg::mon_chan_t  mon_chan;
  logic                     mon_oe, amp_en, amp_rdy, trip;
  logic [15:0]              sel_b;
  logic [7:0]               nr_fields;
  logic                     nr_pd, nr_ref, nr_boost, nr_intref, nr_mon, nr_therm, nr_thi, nr_tlo;
  dac_ctrl_pkg::ctrl_word_t nr_readback;
  logic [7:0]               nr_sel_b;
  int                       fail_count = 0;
  int                       tests_run = 0;
  int                       cycle_cnt = 0;
  int                       wait_cnt;
  row_s                     rows [0:6];

  assign fields = {pd, ref_hi, boost, intref, mon, therm, thi, tlo};
  assign nr_fields = {nr_pd, nr_ref, nr_boost, nr_intref, nr_mon, nr_therm, nr_thi, nr_tlo};

  initial clk_i = 1'h0;
  always #2.5 clk_i = ~clk_i;

  dac_host_model host_u (
    .clk_i               (clk_i),
    .sfr_word_valid_o    (valid),
    .reg_select_hi_o     (sel_hi),
    .reg_select_lo_o     (sel_lo),
    .sfr_address_field_o (addr),
    .word_data_bits_o    (data)
  );

  dac_ctrl_reg #(.NARROW(1'b0), .NUM_CHANNELS(16), .REF_HI_RST(1'b1)) dut_u (
    .clk_i                        (clk_i),
    .sys_rst_i                    (sys_rst_i),
    .sfr_word_valid_i             (valid),
    .reg_select_hi_i              (sel_hi),
    .reg_select_lo_i              (sel_lo),
    .sfr_address_field_i          (addr),
    .word_data_bits_i             (data),
    .load_dac_pin_n_i             (load_dac_pin_n),
    .die_hot_i                    (die_hot),
    .pd_output_state_bit_o        (pd),
    .ref_level_select_bit_o       (ref_hi),
    .amp_boost_bit_o              (boost),
    .int_ref_enable_bit_o         (intref),
    .chan_monitor_enable_bit_o    (mon),
    .thermal_protect_enable_bit_o (therm),
    .toggle_group_hi_enable_o     (thi),
    .toggle_group_lo_enable_o     (tlo),
    .ctrl_readback_o              (readback),
    .mon_channel_o                (mon_chan),
    .monitor_output_pin_oe_o      (mon_oe),
    .amp_enable_o                 (amp_en),
    .amp_ready_o                  (amp_rdy),
    .thermal_trip_o               (trip),
    .toggle_sel_b_o               (sel_b)
  );

  // The second instance sees the same words and pins through the narrow layout.
  dac_ctrl_reg #(.NARROW(1'b1), .NUM_CHANNELS(8), .REF_HI_RST(1'b0)) dut_narrow_u (
    .clk_i                        (clk_i),
    .sys_rst_i                    (sys_rst_i),
    .sfr_word_valid_i             (valid),
    .reg_select_hi_i              (sel_hi),
    .reg_select_lo_i              (sel_lo),
    .sfr_address_field_i          (addr),
    .word_data_bits_i             (data),
    .load_dac_pin_n_i             (load_dac_pin_n),
    .die_hot_i                    (die_hot),
    .pd_output_state_bit_o        (nr_pd),
    .ref_level_select_bit_o       (nr_ref),
    .amp_boost_bit_o              (nr_boost),
    .int_ref_enable_bit_o         (nr_intref),
    .chan_monitor_enable_bit_o    (nr_mon),
    .thermal_protect_enable_bit_o (nr_therm),
    .toggle_group_hi_enable_o     (nr_thi),
    .toggle_group_lo_enable_o     (nr_tlo),
    .ctrl_readback_o              (nr_readback),
    .mon_channel_o                (),
    .monitor_output_pin_oe_o      (),
    .amp_enable_o                 (),
    .amp_ready_o                  (),
    .thermal_trip_o               (),
    .toggle_sel_b_o               (nr_sel_b)
  );

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The run needs about 1,700 cycles; the ceiling leaves ample margin.
  always @(posedge clk_i) begin
    cycle_cnt++;
    if (cycle_cnt >= 5000) begin
      fail_count++;
      stop_test();
    end
  end

  // A pin low period of four cycles covers the three-stage synchroniser.
  task automatic load_pulse();
    load_dac_pin_n = 1'h0;
    repeat (4) @(negedge clk_i);
    load_dac_pin_n = 1'h1;
    repeat (5) @(negedge clk_i);
  endtask

  task automatic check_reset_state();
    check(fields, 8'hC8);
    check(mon_chan, 6'h3F);
    check(mon_oe, 1'h0);
    check(readback, 14'h3200);
    check(nr_fields, 8'h80);
    check(nr_readback, 14'h0800);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    sys_rst_i      = 1'h1;
    load_dac_pin_n = 1'h1;
    die_hot        = 1'h0;
    rows = '{'{2'h0, 4'hC, 14'h3C0C, 14'h3C0C, 14'h0C00},
             '{2'h0, 4'hC, 14'h3FFF, 14'h3F0C, 14'h0FC1},
             '{2'h1, 4'hC, 14'h0000, 14'h3F0C, 14'h0FC1},
             '{2'h2, 4'hC, 14'h0000, 14'h3F0C, 14'h0FC1},
             '{2'h0, 4'hC, 14'h00F3, 14'h0000, 14'h00C1},
             '{2'h0, 4'hC, 14'h2A04, 14'h2A04, 14'h0A00},
             '{2'h0, 4'h9, 14'h3FFF, 14'h2A04, 14'h0A00}};
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'h0;
    repeat (2) @(negedge clk_i);
    check_reset_state();
    check({amp_en, amp_rdy, trip}, 3'h6);
    $display("test reset done");

    foreach (rows[i]) begin
      host_u.send_word(rows[i].sel, rows[i].addr, rows[i].data);
      check(readback, rows[i].exp_rb);
      check(fields, {rows[i].exp_rb[13:8], rows[i].exp_rb[3:2]});
      check(nr_readback, rows[i].exp_n);
      check(nr_fields, {rows[i].exp_n[11:6], rows[i].exp_n[1:0]});
    end
    $display("test table done");

    // Monitor routing, then disable with the channel still selected.
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0200);
    host_u.send_word(2'h0, `SFR_ADDR_MONITOR, 14'h0500);
    check({mon_chan, mon_oe}, {6'h05, 1'h1});
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0000);
    check({mon_chan, mon_oe}, {6'h05, 1'h0});
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0200);
    host_u.send_word(2'h0, `SFR_ADDR_MONITOR, 14'h3F00);
    check(mon_oe, 1'h0);
    $display("test monitor done");

    // Thermal shutdown, refused wake while hot, wake once cool.
    die_hot = 1'h1;
    repeat (5) @(negedge clk_i);
    check({amp_en, trip}, 2'h2);
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0100);
    repeat (4) @(negedge clk_i);
    check({amp_en, trip}, 2'h1);
    host_u.send_word(2'h0, `SFR_ADDR_SOFT_PWRUP, 14'h0000);
    repeat (3) @(negedge clk_i);
    check({amp_en, trip}, 2'h1);
    die_hot = 1'h0;
    repeat (4) @(negedge clk_i);
    host_u.send_word(2'h0, `SFR_ADDR_SOFT_PWRUP, 14'h0000);
    check({amp_en, amp_rdy, trip}, 3'h4);
    wait_cnt = 1;
    while (amp_rdy !== 1'h1 && wait_cnt < 1700) begin
      @(negedge clk_i);
      wait_cnt++;
    end
    check(wait_cnt >= `EXIT_PD_CYC - 2 && wait_cnt <= `EXIT_PD_CYC + 3, 1'h1);
    $display("test thermal done");

    // Toggle groups: low only, hi only, then disabled.
    // Bit 0 is ignored on the wide layout and enables the low group on the narrow one.
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0005);
    load_pulse();
    check(sel_b, 16'h00FF);
    check(nr_sel_b, 8'hFF);
    load_pulse();
    check(sel_b, 16'h0000);
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0008);
    load_pulse();
    check(sel_b, 16'hFF00);
    check(nr_sel_b, 8'h00);
    host_u.send_word(2'h0, `SFR_ADDR_CTRL, 14'h0000);
    load_pulse();
    check(sel_b, 16'h0000);
    $display("test toggle done");

    // Second reset in mid-run.
    @(negedge clk_i);
    sys_rst_i = 1'h1;
    @(negedge clk_i);
    check(readback, 14'h0000);
    sys_rst_i = 1'h0;
    repeat (2) @(negedge clk_i);
    check_reset_state();
    $display("test second reset done");
    stop_test();
  end
endmodule
